// ### rtl/ufcp_pkg.sv
package ufcp_pkg;
    // Frame layout: 8 data bits, no parity, one stop bit
    localparam int DATA_BITS = 8;
    localparam int STOP_BITS = 1;
    // Clock and line rate
    localparam int CLK_HZ = 125000000;
    localparam int BAUD_HZ = 2000000;
    // Cycles per bit at 125 MHz and 2 Mbps, rounded down (62)
    localparam int BIT_CYCLES = CLK_HZ / BAUD_HZ;
    localparam int HALF_CYCLES = BIT_CYCLES / 2;
    localparam int CNT_W = 7;
    localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BIT_CYCLES - 1);
    localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_CYCLES - 1);
    // Receive queue
    localparam int RXQ_DEPTH = 1024;
    localparam int RXQ_AW = 10;
    // Free slots kept in reserve when request-to-send is withdrawn
    localparam logic [RXQ_AW:0] RXQ_HEADROOM = 11'h004;
    // Idle levels: data lines high, handshake high means deasserted
    localparam logic LINE_IDLE = 1'b1;
    localparam logic HS_OFF = 1'b1;
    // Serial engine states, Gray coded along idle-start-data-stop
    typedef enum logic [1:0] {
        SER_IDLE = 2'b00,
        SER_START = 2'b01,
        SER_DATA = 2'b11,
        SER_STOP = 2'b10
    } ufcp_ser_type;
endpackage

// ### rtl/ufcp_link_if.sv
`timescale 1ns/100ps
interface ufcp_link_if;
    logic devTxd;
    logic hostTxd;
    logic devRtsN;
    logic hostRtsN;
    modport device (output devTxd, output devRtsN, input hostTxd, input hostRtsN);
    modport host (output hostTxd, output hostRtsN, input devTxd, input devRtsN);
endinterface

// ### rtl/ufcp_device.sv
`timescale 1ns/100ps
// Function
// - Frame is 8 data, no parity, 1 stop
// - Up to 2 Mbps, handshake in logic
// - Transmit and receive run independently, full duplex
// - Host always uses hardware flow control
// - Device drives RTS out, samples CTS in
// - Low handshake level means asserted
// - Data lines idle high
// - Receive queue holds 1024 bytes
module ufcp_device (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Serial link
    ufcp_link_if.device link,
    // Transmit user side
    input wire logic [7:0] txData,
    input wire logic txValid,
    output logic txReady,
    // Receive user side
    output logic [7:0] rxData,
    output logic rxValid,
    input wire logic rxReady,
    output logic rxFrameError,
    output logic rxOverrun
);
    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic rxdMeta_reg, rxdSync_reg, ctsMeta_reg, ctsSync_reg;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rxdMeta_reg <= 1'b1;
            rxdSync_reg <= 1'b1;
            ctsMeta_reg <= 1'b1;
            ctsSync_reg <= 1'b1;
        end else begin
            rxdMeta_reg <= link.hostTxd;
            rxdSync_reg <= rxdMeta_reg;
            ctsMeta_reg <= link.hostRtsN; // Host RTS is our CTS
            ctsSync_reg <= ctsMeta_reg;
        end
    end
    // Low level means clear to send
    logic ctsOn;
    assign ctsOn = (ctsSync_reg != ufcp_pkg::HS_OFF);

    ////////////////////////////////////////////////////////////////////////////
    // Transmitter
    ufcp_pkg::ufcp_ser_type txState_reg, txState_next;
    logic [ufcp_pkg::CNT_W-1:0] txCnt_reg, txCnt_next;
    logic [2:0] txBit_reg, txBit_next;
    logic [7:0] txShift_reg, txShift_next;
    logic txd_reg, txd_next;
    // CTS only gates the start of a character, never one in flight
    assign txReady = (txState_reg == ufcp_pkg::SER_IDLE) && ctsOn;
    always_comb begin
        txState_next = txState_reg;
        txCnt_next = txCnt_reg;
        txBit_next = txBit_reg;
        txShift_next = txShift_reg;
        txd_next = txd_reg;
        case (txState_reg)
            ufcp_pkg::SER_IDLE: begin
                txd_next = ufcp_pkg::LINE_IDLE;
                if (txValid && ctsOn) begin
                    txShift_next = txData;
                    txd_next = 1'b0;
                    txCnt_next = '0;
                    txState_next = ufcp_pkg::SER_START;
                end
            end
            ufcp_pkg::SER_START: begin
                txCnt_next = txCnt_reg + 1'b1;
                if (txCnt_reg == ufcp_pkg::BIT_LAST) begin // bit time in logic
                    txCnt_next = '0;
                    txBit_next = '0;
                    txd_next = txShift_reg[0];
                    txState_next = ufcp_pkg::SER_DATA;
                end
            end
            ufcp_pkg::SER_DATA: begin
                txCnt_next = txCnt_reg + 1'b1;
                if (txCnt_reg == ufcp_pkg::BIT_LAST) begin
                    txCnt_next = '0;
                    if (txBit_reg == 3'h7) begin
                        txd_next = 1'b1;
                        txState_next = ufcp_pkg::SER_STOP;
                    end else begin
                        txBit_next = txBit_reg + 1'b1;
                        txShift_next = {1'b0, txShift_reg[7:1]};
                        txd_next = txShift_reg[1];
                    end
                end
            end
            ufcp_pkg::SER_STOP: begin
                txCnt_next = txCnt_reg + 1'b1;
                if (txCnt_reg == ufcp_pkg::BIT_LAST) begin // single stop bit
                    txCnt_next = '0;
                    txState_next = ufcp_pkg::SER_IDLE;
                end
            end
            default: begin
                txState_next = ufcp_pkg::SER_IDLE;
                txd_next = ufcp_pkg::LINE_IDLE;
            end
        endcase
    end
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            txState_reg <= ufcp_pkg::SER_IDLE;
            txCnt_reg <= '0;
            txBit_reg <= '0;
            txShift_reg <= '0;
            txd_reg <= 1'b1;
        end else begin
            txState_reg <= txState_next;
            txCnt_reg <= txCnt_next;
            txBit_reg <= txBit_next;
            txShift_reg <= txShift_next;
            txd_reg <= txd_next;
        end
    end
    assign link.devTxd = txd_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Receiver, runs alongside the transmitter
    ufcp_pkg::ufcp_ser_type rxState_reg, rxState_next;
    logic [ufcp_pkg::CNT_W-1:0] rxCnt_reg, rxCnt_next;
    logic [2:0] rxBit_reg, rxBit_next;
    logic [7:0] rxShift_reg, rxShift_next;
    logic rxDone, rxBadStop;
    always_comb begin
        rxState_next = rxState_reg;
        rxCnt_next = rxCnt_reg;
        rxBit_next = rxBit_reg;
        rxShift_next = rxShift_reg;
        rxDone = 1'b0;
        rxBadStop = 1'b0;
        case (rxState_reg)
            ufcp_pkg::SER_IDLE: begin
                if (!rxdSync_reg) begin
                    rxCnt_next = '0;
                    rxState_next = ufcp_pkg::SER_START;
                end
            end
            ufcp_pkg::SER_START: begin
                // Recheck at mid bit to reject glitches
                rxCnt_next = rxCnt_reg + 1'b1;
                if (rxCnt_reg == ufcp_pkg::HALF_LAST) begin
                    rxCnt_next = '0;
                    rxBit_next = '0;
                    rxState_next = rxdSync_reg ? ufcp_pkg::SER_IDLE : ufcp_pkg::SER_DATA;
                end
            end
            ufcp_pkg::SER_DATA: begin
                rxCnt_next = rxCnt_reg + 1'b1;
                if (rxCnt_reg == ufcp_pkg::BIT_LAST) begin
                    rxCnt_next = '0;
                    rxShift_next = {rxdSync_reg, rxShift_reg[7:1]};
                    rxBit_next = rxBit_reg + 1'b1;
                    if (rxBit_reg == 3'h7) begin
                        rxState_next = ufcp_pkg::SER_STOP;
                    end
                end
            end
            ufcp_pkg::SER_STOP: begin
                rxCnt_next = rxCnt_reg + 1'b1;
                if (rxCnt_reg == ufcp_pkg::BIT_LAST) begin
                    // Return at mid stop bit to catch the next start edge early
                    rxCnt_next = '0;
                    rxState_next = ufcp_pkg::SER_IDLE;
                    rxDone = rxdSync_reg;
                    rxBadStop = !rxdSync_reg;
                end
            end
            default: begin
                rxState_next = ufcp_pkg::SER_IDLE;
            end
        endcase
    end
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rxState_reg <= ufcp_pkg::SER_IDLE;
            rxCnt_reg <= '0;
            rxBit_reg <= '0;
            rxShift_reg <= '0;
        end else begin
            rxState_reg <= rxState_next;
            rxCnt_reg <= rxCnt_next;
            rxBit_reg <= rxBit_next;
            rxShift_reg <= rxShift_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive queue of 1024 bytes
    logic [7:0] rxqMem [ufcp_pkg::RXQ_DEPTH];
    logic [ufcp_pkg::RXQ_AW:0] wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next, fill;
    logic [7:0] rxData_reg, rxData_next;
    logic rxValid_reg, rxValid_next, ferr_reg, ferr_next, ovr_reg, ovr_next, rts_reg, rts_next;
    logic qWrite, qRead, qEmpty, qFull;
    assign fill = wrPtr_reg - rdPtr_reg;
    assign qEmpty = (fill == '0);
    assign qFull = fill[ufcp_pkg::RXQ_AW];
    assign qWrite = rxDone && !qFull;
    // Output stage refills when empty or being taken
    assign qRead = !qEmpty && (!rxValid_reg || rxReady);
    always_comb begin
        wrPtr_next = wrPtr_reg + (qWrite ? 1'b1 : 1'b0);
        rdPtr_next = rdPtr_reg + (qRead ? 1'b1 : 1'b0);
        rxData_next = qRead ? rxqMem[rdPtr_reg[ufcp_pkg::RXQ_AW-1:0]] : rxData_reg;
        rxValid_next = qRead ? 1'b1 : (rxReady ? 1'b0 : rxValid_reg);
        ferr_next = rxBadStop;
        ovr_next = rxDone && qFull;
        // Headroom covers characters already in flight from the host
        rts_next = (fill >= ((ufcp_pkg::RXQ_AW+1)'(ufcp_pkg::RXQ_DEPTH) - ufcp_pkg::RXQ_HEADROOM))
            ? ufcp_pkg::HS_OFF : !ufcp_pkg::HS_OFF;
    end
    always_ff @(posedge clk_sys) begin
        if (qWrite) begin
            rxqMem[wrPtr_reg[ufcp_pkg::RXQ_AW-1:0]] <= rxShift_reg;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            rxData_reg <= '0;
            rxValid_reg <= 1'b0;
            ferr_reg <= 1'b0;
            ovr_reg <= 1'b0;
            rts_reg <= ufcp_pkg::HS_OFF;
        end else begin
            wrPtr_reg <= wrPtr_next;
            rdPtr_reg <= rdPtr_next;
            rxData_reg <= rxData_next;
            rxValid_reg <= rxValid_next;
            ferr_reg <= ferr_next;
            ovr_reg <= ovr_next;
            rts_reg <= rts_next;
        end
    end
    assign rxData = rxData_reg;
    assign rxValid = rxValid_reg;
    assign rxFrameError = ferr_reg;
    assign rxOverrun = ovr_reg;
    assign link.devRtsN = rts_reg;
endmodule

// ### rtl/ufcp_host.sv
`timescale 1ns/100ps
module ufcp_host (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Serial link
    ufcp_link_if.host link,
    // Transmit user side
    input wire logic [7:0] txData,
    input wire logic txValid,
    output logic txReady,
    // Receive user side
    output logic [7:0] rxData,
    output logic rxValid,
    input wire logic rxStall
);
    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic rxdMeta_reg, rxdSync_reg, ctsMeta_reg, ctsSync_reg;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rxdMeta_reg <= 1'b1;
            rxdSync_reg <= 1'b1;
            ctsMeta_reg <= 1'b1;
            ctsSync_reg <= 1'b1;
        end else begin
            rxdMeta_reg <= link.devTxd;
            rxdSync_reg <= rxdMeta_reg;
            ctsMeta_reg <= link.devRtsN;
            ctsSync_reg <= ctsMeta_reg;
        end
    end
    // Always honour device RTS, low means go
    logic ctsOn;
    assign ctsOn = (ctsSync_reg != ufcp_pkg::HS_OFF);

    ////////////////////////////////////////////////////////////////////////////
    // Transmitter: one counter walks start, 8 data and stop bits
    logic busy_reg, busy_next;
    logic [ufcp_pkg::CNT_W-1:0] tCnt_reg, tCnt_next;
    logic [3:0] tBit_reg, tBit_next;
    logic [9:0] tFrame_reg, tFrame_next;
    assign txReady = !busy_reg && ctsOn;
    always_comb begin
        busy_next = busy_reg;
        tCnt_next = tCnt_reg;
        tBit_next = tBit_reg;
        tFrame_next = tFrame_reg;
        if (!busy_reg) begin
            if (txValid && ctsOn) begin
                busy_next = 1'b1;
                tCnt_next = '0;
                tBit_next = '0;
                tFrame_next = {1'b1, txData, 1'b0};
            end
        end else begin
            tCnt_next = tCnt_reg + 1'b1;
            if (tCnt_reg == ufcp_pkg::BIT_LAST) begin
                tCnt_next = '0;
                tBit_next = tBit_reg + 1'b1;
                tFrame_next = {1'b1, tFrame_reg[9:1]};
                if (tBit_reg == 4'h9) begin
                    busy_next = 1'b0;
                end
            end
        end
    end
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            busy_reg <= 1'b0;
            tCnt_reg <= '0;
            tBit_reg <= '0;
            tFrame_reg <= 10'h3FF;
        end else begin
            busy_reg <= busy_next;
            tCnt_reg <= tCnt_next;
            tBit_reg <= tBit_next;
            tFrame_reg <= tFrame_next;
        end
    end
    assign link.hostTxd = tFrame_reg[0];

    ////////////////////////////////////////////////////////////////////////////
    // Receiver, one-byte holding register
    logic rBusy_reg, rBusy_next, rValid_reg, rValid_next;
    logic [ufcp_pkg::CNT_W-1:0] rCnt_reg, rCnt_next;
    logic [3:0] rBit_reg, rBit_next;
    logic [7:0] rShift_reg, rShift_next, rData_reg, rData_next;
    // Start-bit test, declared ahead of its use
    function automatic logic rdxLow();
        return !rxdSync_reg;
    endfunction
    always_comb begin
        rBusy_next = rBusy_reg;
        rCnt_next = rCnt_reg;
        rBit_next = rBit_reg;
        rShift_next = rShift_reg;
        rData_next = rData_reg;
        rValid_next = 1'b0;
        if (!rBusy_reg) begin
            if (!rdxLow()) begin
                rCnt_next = '0;
            end else begin
                // Start at half a bit so later samples fall mid bit
                rBusy_next = 1'b1;
                rBit_next = '0;
                rCnt_next = ufcp_pkg::HALF_LAST;
            end
        end else begin
            rCnt_next = rCnt_reg + 1'b1;
            if (rCnt_reg == ufcp_pkg::BIT_LAST) begin
                rCnt_next = '0;
                rBit_next = rBit_reg + 1'b1;
                if (rBit_reg == 4'h0 && rxdSync_reg) begin
                    rBusy_next = 1'b0;
                end else if (rBit_reg == 4'h9) begin
                    rBusy_next = 1'b0;
                    rData_next = rShift_reg;
                    rValid_next = rxdSync_reg;
                end else if (rBit_reg != 4'h0) begin
                    rShift_next = {rxdSync_reg, rShift_reg[7:1]};
                end
            end
        end
    end
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rBusy_reg <= 1'b0;
            rValid_reg <= 1'b0;
            rCnt_reg <= '0;
            rBit_reg <= '0;
            rShift_reg <= '0;
            rData_reg <= '0;
        end else begin
            rBusy_reg <= rBusy_next;
            rValid_reg <= rValid_next;
            rCnt_reg <= rCnt_next;
            rBit_reg <= rBit_next;
            rShift_reg <= rShift_next;
            rData_reg <= rData_next;
        end
    end
    assign rxData = rData_reg;
    assign rxValid = rValid_reg;
    // Host RTS drives device CTS; stall holds the device off
    assign link.hostRtsN = reset ? ufcp_pkg::HS_OFF : rxStall;
endmodule

// ### sim/ufcp_link_checker.sv
`timescale 1ns/100ps
module ufcp_link_checker (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Link lines
    input wire logic devTxd,
    input wire logic hostTxd,
    input wire logic devRtsN,
    input wire logic hostRtsN
);
    localparam int BIT = ufcp_pkg::BIT_CYCLES;
    localparam int FRAME = 10 * BIT;
    logic [9:0] devCnt_reg;
    logic [9:0] hostCnt_reg;
    logic devPrev_reg;
    logic hostPrev_reg;

    default clocking cb @(posedge clk_sys);
    endclocking

    ////////////////////////////////////////////////////////////////////////////////
    // Cycle position inside each frame, 0 when idle; prev starts high so reset is no edge
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            devCnt_reg <= 10'h000;
            hostCnt_reg <= 10'h000;
            devPrev_reg <= 1'b1;
            hostPrev_reg <= 1'b1;
        end else begin
            devPrev_reg <= devTxd;
            hostPrev_reg <= hostTxd;
            if (devCnt_reg != 10'h000) begin
                devCnt_reg <= (devCnt_reg == 10'(FRAME - 1)) ? 10'h000 : devCnt_reg + 10'h001;
            end else if (devPrev_reg && !devTxd) begin
                devCnt_reg <= 10'h001;
            end
            if (hostCnt_reg != 10'h000) begin
                hostCnt_reg <= (hostCnt_reg == 10'(FRAME - 1)) ? 10'h000 : hostCnt_reg + 10'h001;
            end else if (hostPrev_reg && !hostTxd) begin
                hostCnt_reg <= 10'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Start of a frame on either line
    sequence s_dev_start;
        devCnt_reg == 10'h000 && devPrev_reg && !devTxd;
    endsequence
    sequence s_host_start;
        hostCnt_reg == 10'h000 && hostPrev_reg && !hostTxd;
    endsequence

    // Reset levels and release
    property p_reset_idle;
        reset |=> devTxd && hostTxd && devRtsN;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("line not idle in reset");
    property p_cts_reset;
        reset |-> hostRtsN;
    endproperty
    a_cts_reset: assert property (p_cts_reset) else $error("host rts asserted in reset");
    property p_rts_release;
        disable iff (reset) $fell(reset) |=> !devRtsN;
    endproperty
    a_rts_release: assert property (p_rts_release) else $error("device rts not asserted");

    // Frame shape on the device line
    property p_dev_start_bit;
        disable iff (reset) devCnt_reg inside {[1:BIT-1]} |-> !devTxd;
    endproperty
    a_dev_start_bit: assert property (p_dev_start_bit) else $error("device start bit short");
    property p_dev_stop_bit;
        disable iff (reset) devCnt_reg inside {[FRAME-BIT:FRAME-1]} |-> devTxd;
    endproperty
    a_dev_stop_bit: assert property (p_dev_stop_bit) else $error("device stop bit low");
    property p_dev_hold;
        disable iff (reset) (devCnt_reg != 10'h000 && devCnt_reg % BIT != 0) |-> $stable(devTxd);
    endproperty
    a_dev_hold: assert property (p_dev_hold) else $error("device bit changed mid bit");

    // Frame shape on the host line
    property p_host_stop_bit;
        disable iff (reset) hostCnt_reg inside {[FRAME-BIT:FRAME-1]} |-> hostTxd;
    endproperty
    a_host_stop_bit: assert property (p_host_stop_bit) else $error("host stop bit low");
    property p_host_hold;
        disable iff (reset) (hostCnt_reg != 10'h000 && hostCnt_reg % BIT != 0) |-> $stable(hostTxd);
    endproperty
    a_host_hold: assert property (p_host_hold) else $error("host bit changed mid bit");

    // No new frame after clear-to-send has been off for four cycles
    property p_dev_cts;
        disable iff (reset) s_dev_start |->
            !($past(hostRtsN, 1) && $past(hostRtsN, 2) && $past(hostRtsN, 3) && $past(hostRtsN, 4));
    endproperty
    a_dev_cts: assert property (p_dev_cts) else $error("device sent with cts off");
    property p_host_rts;
        disable iff (reset) s_host_start |->
            !($past(devRtsN, 1) && $past(devRtsN, 2) && $past(devRtsN, 3) && $past(devRtsN, 4));
    endproperty
    a_host_rts: assert property (p_host_rts) else $error("host sent with rts off");
endmodule

// ### sim/uart_flow_controlled_port_bench.sv
`timescale 1ns/100ps
module uart_flow_controlled_port_bench;
    localparam int BIT = ufcp_pkg::BIT_CYCLES;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [7:0] devTxData = 8'h00, hostTxData = 8'h00, wireByte, devRxData, hostRxData, d2RxData, d2Last;
    logic devTxValid = 1'b0, hostTxValid = 1'b0, devRxReady = 1'b0, hostRxStall = 1'b0;
    logic devTxReady, hostTxReady, devRxValid, hostRxValid, devFrameErr, devOverrun, d2RxValid, d2FrameErr;
    logic [7:0] toHost[3] = '{8'hA5, 8'h01, 8'h80};
    logic [7:0] toDev[3] = '{8'h5A, 8'hFE, 8'h00};
    logic [7:0] hostGot[$];
    int failures = 0, checks_done = 0, d2Valids = 0, d2Errs = 0, devFlags = 0;
    ufcp_link_if link();
    ufcp_link_if link2();

    always #4 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////////////
    // Both ends face each other; second device faces the bench for fault frames
    ufcp_device i_ufcp_device (.clk_sys(clk_sys), .reset(reset), .link(link), .txData(devTxData),
        .txValid(devTxValid), .txReady(devTxReady), .rxData(devRxData), .rxValid(devRxValid),
        .rxReady(devRxReady), .rxFrameError(devFrameErr), .rxOverrun(devOverrun));
    ufcp_host i_ufcp_host (.clk_sys(clk_sys), .reset(reset), .link(link), .txData(hostTxData),
        .txValid(hostTxValid), .txReady(hostTxReady), .rxData(hostRxData), .rxValid(hostRxValid),
        .rxStall(hostRxStall));
    ufcp_device i_ufcp_device_2 (.clk_sys(clk_sys), .reset(reset), .link(link2), .txData(8'h00),
        .txValid(1'b0), .txReady(), .rxData(d2RxData), .rxValid(d2RxValid), .rxReady(1'b1),
        .rxFrameError(d2FrameErr), .rxOverrun());
    ufcp_link_checker i_ufcp_link_checker (.clk_sys(clk_sys), .reset(reset), .devTxd(link.devTxd),
        .hostTxd(link.hostTxd), .devRtsN(link.devRtsN), .hostRtsN(link.hostRtsN));
    assign link2.hostRtsN = 1'b0;

    // One-cycle pulses are caught on the falling edge, away from register updates
    always @(negedge clk_sys) begin
        if (hostRxValid === 1'b1) hostGot.push_back(hostRxData);
        if (d2RxValid === 1'b1) begin
            d2Valids++;
            d2Last = d2RxData;
        end
        if (d2FrameErr === 1'b1) d2Errs++;
        // Clean link must never flag an error or a dropped byte
        if (devFrameErr !== 1'b0 || devOverrun !== 1'b0) devFlags++;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic pick(input int sel);
        case (sel)
            0: return devTxReady;
            1: return hostTxReady;
            2: return devRxValid;
            default: return !link.devTxd;
        endcase
    endfunction

    // Bounded wait, checked just after each edge where values have settled
    task automatic await(input int sel);
        int n;
        n = 0;
        while (pick(sel) !== 1'b1) begin
            @(posedge clk_sys);
            #1;
            n++;
            if (n > 3000) begin
                failures++;
                $display("TIMEOUT at %0t on %0d", $time, sel);
                final_report();
            end
        end
    endtask

    // Valid stays up on return so back-to-back calls never re-assign it in one step
    task automatic send(input int side, input logic [7:0] b);
        if (side == 0) begin
            devTxData = b;
            devTxValid = 1'b1;
        end else begin
            hostTxData = b;
            hostTxValid = 1'b1;
        end
        await(side);
        @(posedge clk_sys);
        #1;
    endtask

    task automatic read(input logic [7:0] exp);
        await(2);
        check(devRxData, exp);
        @(posedge clk_sys);
        #1;
    endtask

    // Bench plays a host line on the second link, stop bit chosen by caller
    task automatic line_frame(input logic [7:0] b, input logic stopBit);
        logic [9:0] bits;
        bits = {stopBit, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            link2.hostTxd = bits[i];
            repeat (BIT) @(posedge clk_sys);
            #1;
        end
        link2.hostTxd = 1'b1;
        repeat (BIT) @(posedge clk_sys);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        link2.hostTxd = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        check(link.devTxd, 1'b1);
        check(link.hostTxd, 1'b1);
        check(link.devRtsN, 1'b1);
        repeat (3) @(posedge clk_sys);
        #1;
        reset = 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
        check(link.devRtsN, 1'b0);
        $display("test reset done");
        // Both directions at once; device queue holds its bytes until read
        fork
            begin
                foreach (toHost[i]) send(0, toHost[i]);
                devTxValid = 1'b0;
            end
            begin
                foreach (toDev[i]) send(1, toDev[i]);
                hostTxValid = 1'b0;
            end
            begin
                await(3);
                repeat (BIT / 2) @(posedge clk_sys);
                for (int i = 0; i < 8; i++) begin
                    repeat (BIT) @(posedge clk_sys);
                    wireByte[i] = link.devTxd;
                end
                repeat (BIT) @(posedge clk_sys);
                check(wireByte, 8'hA5);
                check(link.devTxd, 1'b1);
            end
        join
        repeat (700) @(posedge clk_sys);
        #1;
        check(8'(hostGot.size()), 8'h03);
        foreach (toHost[i]) check(hostGot[i], toHost[i]);
        devRxReady = 1'b1;
        foreach (toDev[i]) read(toDev[i]);
        devRxReady = 1'b0;
        $display("test duplex done");
        // Clear-to-send withdrawn: request must wait
        hostRxStall = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        check(devTxReady, 1'b0);
        devTxData = 8'h3C;
        devTxValid = 1'b1;
        repeat (200) @(posedge clk_sys);
        #1;
        check(link.devTxd, 1'b1);
        hostRxStall = 1'b0;
        send(0, 8'h3C);
        devTxValid = 1'b0;
        repeat (700) @(posedge clk_sys);
        #1;
        check(hostGot[3], 8'h3C);
        $display("test flow control done");
        // Bad stop bit is dropped, good one is delivered
        line_frame(8'h96, 1'b0);
        check(8'(d2Errs), 8'h01);
        check(8'(d2Valids), 8'h00);
        line_frame(8'h96, 1'b1);
        check(8'(d2Valids), 8'h01);
        check(d2Last, 8'h96);
        check(8'(devFlags), 8'h00);
        $display("test framing done");
        final_report();
    end
endmodule
